// ### cksp_pkg.sv
// cksp_pkg: constants, modes and bus carriers for the clock select and prescaler block
// assumes a single 100 MHz system clock domain and an APB master with 32-bit data
package cksp_pkg;

    // register byte offsets
    localparam logic [7:0] SYSCTL2_OFS = 8'h00;
    localparam logic [7:0] CLKSTOP2_OFS = 8'h04;
    localparam logic [7:0] OSCSTAT_OFS = 8'h08;

    // field positions
    localparam int DIV_LO_POS = 0;
    localparam int DIV_HI_POS = 1;
    localparam int OSC_CHOICE_POS = 0;
    localparam int PIN_LEVEL_POS = 1;

    // values after reset
    localparam logic [1:0] SYSCTL2_RST = 2'h0;
    localparam logic [7:0] CLKSTOP2_RST = 8'hFF;
    localparam logic [16:0] PRES_S_RST = 17'h00000;
    localparam logic [7:0] PRES_W_RST = 8'h00;

    // watch clock is divided by four before prescaler W
    localparam int WATCH_PREDIV = 4;
    localparam logic [1:0] WATCH_PREDIV_LAST = 2'(WATCH_PREDIV - 1);

    // standby bit order in module_clock_stop_two
    localparam int SB_ADDR_BREAK = 7;
    localparam int SB_PULSE_UNIT = 6;
    localparam int SB_TWO_WIRE = 5;
    localparam int SB_PWM_SECOND = 4;
    localparam int SB_ASYNC_COUNTER = 3;
    localparam int SB_WATCHDOG = 2;
    localparam int SB_PWM_FIRST = 1;
    localparam int SB_LCD_DRIVER = 0;

    typedef enum logic [2:0] {
        PWR_ACTIVE_HS,
        PWR_ACTIVE_MS,
        PWR_SLEEP_HS,
        PWR_SLEEP_MS,
        PWR_SUBACTIVE,
        PWR_SUBSLEEP,
        PWR_WATCH,
        PWR_STANDBY
    } cksp_pwr_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } cksp_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } cksp_apb_rsp_s;

endpackage

// ### cksp_top.sv
// cksp_top: oscillator choice capture, prescalers S and W, module standby bits, APB slave
// assumes all inputs synchronous to ref_clk_i; watch clock arrives as a one-cycle tick
//
// Behaviour
// - pin level during reset picks source: low external oscillator, high on-chip.
// - pin level captured on reset release and held; pin steady through reset.
// - only external or power-on reset resamples; watchdog reset keeps choice.
// - choice flag and pin level flag read 0 external, 1 on-chip.
// - prescaler S is a 17-bit up-counter on the system clock.
// - reset clears prescaler S; it counts up once reset is exited.
// - prescaler S held at zero in standby, watch, subactive, subsleep.
// - prescaler S has no processor read or write path.
// - medium-speed modes feed prescaler S through the selected divider ratio.
// - prescaler S bits are offered as shared divided clocks.
// - prescaler W is an 8-bit up-counter on watch clock divided by four.
// - prescaler W bits are offered as divided peripheral clocks.
// - reset clears prescaler W; it counts up once reset is exited.
// - prescaler W halts only in standby; runs in watch and sub modes.
// - eight standby bits reset to 1; clearing a bit stops its module.
`timescale 1ns/1ps

module cksp_top #(
    parameter int PRES_S_W = 17,
    parameter int PRES_W_W = 8,
    parameter int MOD_CNT = 8,
    // ratios for divider field values 0..3, each 1..256
    parameter logic [3:0][8:0] MS_DIV_TAB = {9'd256, 9'd64, 9'd32, 9'd16}
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic wdt_reset_i,
    // pins and power state
    input wire logic osc_select_pin_i,
    input wire logic watch_tick_i,
    input wire cksp_pkg::cksp_pwr_e pwr_mode_i,
    // register bus
    input wire cksp_pkg::cksp_apb_req_s apb_req_i,
    output cksp_pkg::cksp_apb_rsp_s apb_rsp_o,
    // clock outputs
    output logic [PRES_S_W-1:0] pres_s_taps_o,
    output logic [PRES_W_W-1:0] pres_w_taps_o,
    output logic [MOD_CNT-1:0] module_run_o,
    output logic oscillator_choice_o
);

    // oscillator choice
    logic captured_q;
    logic captured_d;
    logic osc_choice_q;
    logic osc_choice_d;
    logic pin_level_q;
    logic pin_level_d;

    // after async reset release the first edge takes the pin; a watchdog
    // reset never touches these flops, so the old choice survives
    assign captured_d = 1'b1;
    assign osc_choice_d = captured_q ? osc_choice_q : osc_select_pin_i;
    assign pin_level_d = captured_q ? pin_level_q : osc_select_pin_i;

    // only the pin reset clears this; the watchdog path has no way in
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            captured_q <= 1'b0;
        end
        else
        begin
            captured_q <= captured_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            osc_choice_q <= 1'b0;
        end
        else
        begin
            osc_choice_q <= osc_choice_d;
        end
    end

    // kept apart from the choice so a later remap of either stays local
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pin_level_q <= 1'b0;
        end
        else
        begin
            pin_level_q <= pin_level_d;
        end
    end

    // register bus decode
    logic acc_w;
    logic wr_w;
    logic rd_w;
    logic hit_ctl_w;
    logic hit_stop_w;
    logic hit_stat_w;
    logic mapped_w;
    logic pready_q;

    assign acc_w = apb_req_i.psel & apb_req_i.penable;
    assign hit_ctl_w = apb_req_i.paddr == cksp_pkg::SYSCTL2_OFS;
    assign hit_stop_w = apb_req_i.paddr == cksp_pkg::CLKSTOP2_OFS;
    assign hit_stat_w = apb_req_i.paddr == cksp_pkg::OSCSTAT_OFS;
    // prescaler S is deliberately absent from the map
    assign mapped_w = hit_ctl_w | hit_stop_w | hit_stat_w;
    assign wr_w = acc_w & pready_q & apb_req_i.pwrite;
    assign rd_w = acc_w & ~pready_q & ~apb_req_i.pwrite;

    // control registers
    logic [1:0] div_sel_q;
    logic [1:0] div_sel_d;
    logic [MOD_CNT-1:0] stop_bits_q;
    logic [MOD_CNT-1:0] stop_bits_d;

    assign div_sel_d = (wr_w & hit_ctl_w)
        ? {apb_req_i.pwdata[cksp_pkg::DIV_HI_POS], apb_req_i.pwdata[cksp_pkg::DIV_LO_POS]}
        : div_sel_q;
    assign stop_bits_d = (wr_w & hit_stop_w) ? apb_req_i.pwdata[MOD_CNT-1:0] : stop_bits_q;

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            div_sel_q <= cksp_pkg::SYSCTL2_RST;
        end
        else if (wdt_reset_i)
        begin
            div_sel_q <= cksp_pkg::SYSCTL2_RST;
        end
        else
        begin
            div_sel_q <= div_sel_d;
        end
    end

    // watchdog reset wakes every module again, same as the pin reset
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            stop_bits_q <= cksp_pkg::CLKSTOP2_RST;
        end
        else if (wdt_reset_i)
        begin
            stop_bits_q <= cksp_pkg::CLKSTOP2_RST;
        end
        else
        begin
            stop_bits_q <= stop_bits_d;
        end
    end

    // read data
    logic [31:0] rdata_w;
    logic [31:0] ctl_w;
    logic [31:0] stat_w;

    // fields placed by their positions, every other bit reads 0
    assign ctl_w = (32'(div_sel_q[0]) << cksp_pkg::DIV_LO_POS)
                 | (32'(div_sel_q[1]) << cksp_pkg::DIV_HI_POS);
    assign stat_w = (32'(osc_choice_q) << cksp_pkg::OSC_CHOICE_POS)
                  | (32'(pin_level_q) << cksp_pkg::PIN_LEVEL_POS);
    assign rdata_w = hit_ctl_w ? ctl_w
                   : hit_stop_w ? {{(32-MOD_CNT){1'b0}}, stop_bits_q}
                   : hit_stat_w ? stat_w
                   : 32'h0;

    // one wait state: pready rises in the second access cycle
    logic pslverr_q;
    logic [31:0] prdata_q;

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pready_q <= 1'b0;
        end
        else
        begin
            pready_q <= acc_w & ~pready_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pslverr_q <= 1'b0;
        end
        else
        begin
            pslverr_q <= acc_w & ~pready_q & ~mapped_w;
        end
    end

    // data is zero outside the answer cycle, so a stale read never lingers
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            prdata_q <= 32'h0;
        end
        else
        begin
            prdata_q <= (rd_w & mapped_w) ? rdata_w : 32'h0;
        end
    end

    assign apb_rsp_o = {pready_q, pslverr_q, prdata_q};

    // power state decode
    logic ms_mode_w;
    logic s_hold_w;
    logic w_halt_w;

    assign ms_mode_w = (pwr_mode_i == cksp_pkg::PWR_ACTIVE_MS)
                     | (pwr_mode_i == cksp_pkg::PWR_SLEEP_MS);
    assign s_hold_w = (pwr_mode_i == cksp_pkg::PWR_STANDBY)
                    | (pwr_mode_i == cksp_pkg::PWR_WATCH)
                    | (pwr_mode_i == cksp_pkg::PWR_SUBACTIVE)
                    | (pwr_mode_i == cksp_pkg::PWR_SUBSLEEP);
    assign w_halt_w = pwr_mode_i == cksp_pkg::PWR_STANDBY;

    // medium-speed divider ahead of prescaler S
    logic [7:0] ms_cnt_q;
    logic [7:0] ms_cnt_d;
    logic [7:0] ms_last_w;
    logic ms_wrap_w;
    logic s_tick_w;

    assign ms_last_w = 8'(MS_DIV_TAB[div_sel_q] - 9'd1);
    assign ms_wrap_w = ms_cnt_q >= ms_last_w;
    assign s_tick_w = ms_mode_w ? ms_wrap_w : 1'b1;
    assign ms_cnt_d = (~ms_mode_w | s_hold_w | ms_wrap_w) ? 8'h00 : 8'(ms_cnt_q + 8'h01);

    // prescaler S
    logic [PRES_S_W-1:0] pres_s_q;
    logic [PRES_S_W-1:0] pres_s_d;

    // natural wrap from all ones to zero
    assign pres_s_d = s_hold_w ? PRES_S_W'(cksp_pkg::PRES_S_RST)
                    : s_tick_w ? PRES_S_W'(pres_s_q + 1'b1)
                    : pres_s_q;

    // watch predivider and prescaler W
    logic [1:0] wdiv_q;
    logic [1:0] wdiv_d;
    logic w_tick_w;
    logic [PRES_W_W-1:0] pres_w_q;
    logic [PRES_W_W-1:0] pres_w_d;

    assign w_tick_w = watch_tick_i & ~w_halt_w & (wdiv_q == cksp_pkg::WATCH_PREDIV_LAST);
    assign wdiv_d = (watch_tick_i & ~w_halt_w) ? 2'(wdiv_q + 2'h1) : wdiv_q;
    assign pres_w_d = w_tick_w ? PRES_W_W'(pres_w_q + 1'b1) : pres_w_q;

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ms_cnt_q <= 8'h00;
        end
        else if (wdt_reset_i)
        begin
            ms_cnt_q <= 8'h00;
        end
        else
        begin
            ms_cnt_q <= ms_cnt_d;
        end
    end

    // the watchdog reset restarts the count as well, like the pin reset
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pres_s_q <= PRES_S_W'(cksp_pkg::PRES_S_RST);
        end
        else if (wdt_reset_i)
        begin
            pres_s_q <= PRES_S_W'(cksp_pkg::PRES_S_RST);
        end
        else
        begin
            pres_s_q <= pres_s_d;
        end
    end

    // predivider phase restarts too, so the first W step needs four ticks
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wdiv_q <= 2'h0;
        end
        else if (wdt_reset_i)
        begin
            wdiv_q <= 2'h0;
        end
        else
        begin
            wdiv_q <= wdiv_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pres_w_q <= PRES_W_W'(cksp_pkg::PRES_W_RST);
        end
        else if (wdt_reset_i)
        begin
            pres_w_q <= PRES_W_W'(cksp_pkg::PRES_W_RST);
        end
        else
        begin
            pres_w_q <= pres_w_d;
        end
    end

    // taps are the counter bits themselves, so they stay phase-aligned
    assign pres_s_taps_o = pres_s_q;
    assign pres_w_taps_o = pres_w_q;
    assign oscillator_choice_o = osc_choice_q;

    // per-module run enables; a cleared bit parks the module
    genvar gi;
    generate
        for (gi = 0; gi < MOD_CNT; gi++)
        begin : g_mod
            assign module_run_o[gi] = stop_bits_q[gi];
        end
    endgenerate

endmodule // cksp_top

// ### cksp_top_chk.sv
// cksp_top_chk: port-level assertions for the clock select and prescaler block
// assumes only the top module's ports; bound into cksp_top at the foot of this file
`timescale 1ns/1ps
module cksp_top_chk #(
    parameter int PRES_S_W = 17,
    parameter int PRES_W_W = 8,
    parameter int MOD_CNT = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic wdt_reset_i,
    // pins, mode, bus
    input wire logic osc_select_pin_i,
    input wire logic watch_tick_i,
    input wire cksp_pkg::cksp_pwr_e pwr_mode_i,
    input wire cksp_pkg::cksp_apb_req_s apb_req_i,
    input wire cksp_pkg::cksp_apb_rsp_s apb_rsp_o,
    // watched outputs
    input wire logic [PRES_S_W-1:0] pres_s_taps_o,
    input wire logic [PRES_W_W-1:0] pres_w_taps_o,
    input wire logic [MOD_CNT-1:0] module_run_o,
    input wire logic oscillator_choice_o
);
    wire low_pwr = pwr_mode_i inside {cksp_pkg::PWR_STANDBY, cksp_pkg::PWR_WATCH,
        cksp_pkg::PWR_SUBACTIVE, cksp_pkg::PWR_SUBSLEEP};
    wire high_spd = pwr_mode_i inside {cksp_pkg::PWR_ACTIVE_HS, cksp_pkg::PWR_SLEEP_HS};
    wire mapped = apb_req_i.paddr inside {cksp_pkg::SYSCTL2_OFS, cksp_pkg::CLKSTOP2_OFS,
        cksp_pkg::OSCSTAT_OFS};
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    s_hold_a: assert property (low_pwr |=> pres_s_taps_o == '0)
        else $error("prescaler S not held at zero");
    s_count_a: assert property ((high_spd && !wdt_reset_i) |=>
        pres_s_taps_o == PRES_S_W'($past(pres_s_taps_o) + 1'b1))
        else $error("prescaler S missed a step");
    w_stop_a: assert property ((pwr_mode_i == cksp_pkg::PWR_STANDBY && !wdt_reset_i)
        |=> $stable(pres_w_taps_o)) else $error("prescaler W moved in standby");
    w_step_a: assert property ((pres_w_taps_o != $past(pres_w_taps_o) &&
        !$past(wdt_reset_i)) |-> pres_w_taps_o == PRES_W_W'($past(pres_w_taps_o) + 1'b1))
        else $error("prescaler W jumped");
    wdt_keep_a: assert property (wdt_reset_i |=> $stable(oscillator_choice_o))
        else $error("watchdog reset changed oscillator choice");
    wdt_clear_a: assert property (wdt_reset_i |=>
        module_run_o == '1 && pres_s_taps_o == '0) else $error("watchdog reset incomplete");
    osc_hold_a: assert property ($past(rst_b_i, 2) |-> $stable(oscillator_choice_o))
        else $error("oscillator choice changed after reset");
    osc_load_a: assert property ($rose(rst_b_i) |=>
        oscillator_choice_o == $past(osc_select_pin_i)) else $error("pin level not captured");
    bus_err_a: assert property ((apb_rsp_o.pready && !mapped) |->
        apb_rsp_o.pslverr && apb_rsp_o.prdata == '0) else $error("unmapped access accepted");
    cover property (pwr_mode_i == cksp_pkg::PWR_ACTIVE_MS && $changed(pres_s_taps_o));
    cover property (wdt_reset_i);
    cover property (apb_rsp_o.pslverr);
endmodule // cksp_top_chk

bind cksp_top cksp_top_chk #(.PRES_S_W(PRES_S_W), .PRES_W_W(PRES_W_W), .MOD_CNT(MOD_CNT))
    chk_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .wdt_reset_i(wdt_reset_i),
    .osc_select_pin_i(osc_select_pin_i), .watch_tick_i(watch_tick_i),
    .pwr_mode_i(pwr_mode_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
    .pres_s_taps_o(pres_s_taps_o), .pres_w_taps_o(pres_w_taps_o),
    .module_run_o(module_run_o), .oscillator_choice_o(oscillator_choice_o));

// ### cksp_periph_model.sv
// cksp_periph_model: a peripheral that works on one prescaler tap while its clock runs
// assumes tap and run enable come straight from the block, on the system clock
`timescale 1ns/1ps
module cksp_periph_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // divided clock and enable
    input wire logic tap_i,
    input wire logic run_i,
    // work done
    output logic [15:0] ticks_o
);
    logic tap_q;
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tap_q <= 1'b0;
            ticks_o <= 16'h0000;
        end
        else
        begin
            tap_q <= tap_i;
            // a module in standby sees no edges at all
            if (run_i && tap_i && !tap_q)
            begin
                ticks_o <= ticks_o + 16'h0001;
            end
        end
    end
endmodule // cksp_periph_model

// ### tb_top.sv
// tb_top: self-checking bench for the clock select and prescaler block
// assumes the checker is bound in and the peripheral model sits on tap bit 3
`timescale 1ns/1ps
module tb_top;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wdt = 1'b0;
    logic pin = 1'b1;
    logic tick = 1'b0;
    cksp_pkg::cksp_pwr_e mode = cksp_pkg::PWR_ACTIVE_HS;
    cksp_pkg::cksp_apb_req_s req = '0;
    cksp_pkg::cksp_apb_rsp_s rsp;
    logic [16:0] s;
    logic [7:0] w;
    logic [7:0] run;
    logic osc;
    logic [15:0] pt;
    logic [31:0] rd, v, u;
    logic err;
    int num_errors = 0;
    int n_compared = 0;
    // rows: address, write data, read-back, error flag
    logic [7:0] ra [4] = '{8'h04, 8'h00, 8'h08, 8'h0C};
    logic [31:0] rw [4] = '{32'h5A, 32'h1, 32'hFF, 32'h1};
    logic [31:0] rx [4] = '{32'h5A, 32'h1, 32'h3, 32'h0};
    logic re [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    int dv [4] = '{16, 32, 64, 256};
    cksp_pkg::cksp_pwr_e lpm [4] = '{cksp_pkg::PWR_WATCH, cksp_pkg::PWR_SUBACTIVE,
        cksp_pkg::PWR_SUBSLEEP, cksp_pkg::PWR_STANDBY};
    always #5 ref_clk_i = ~ref_clk_i;
    cksp_top dut_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .wdt_reset_i(wdt),
        .osc_select_pin_i(pin), .watch_tick_i(tick), .pwr_mode_i(mode), .apb_req_i(req),
        .apb_rsp_o(rsp), .pres_s_taps_o(s), .pres_w_taps_o(w), .module_run_o(run),
        .oscillator_choice_o(osc));
    cksp_periph_model per_u (.clk_i(ref_clk_i), .rst_b_i(rst_b_i), .tap_i(s[3]),
        .run_i(run[0]), .ticks_o(pt));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge ref_clk_i);
        req.penable <= 1'b1;
        // no local limit: a hang is caught by the global 100000 ns timeout
        do
        begin
            @(posedge ref_clk_i);
        end
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask
    task stop_test;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #100000;
        num_errors++;
        stop_test;
    end
    initial
    begin
        repeat (5) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        chk(osc, 1);
        chk(run, 8'hFF);
        v = s;
        u = pt;
        repeat (160) @(posedge ref_clk_i);
        chk(32'(s) - v, 160);
        chk(32'(pt) - u, 10);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, ra[i], rw[i]);
            apb(1'b0, ra[i], 32'h0);
            chk(rd, rx[i]);
            chk(err, re[i]);
        end
        chk(run, 8'h5A);
        u = pt;
        repeat (64) @(posedge ref_clk_i);
        chk(pt, u);
        mode <= cksp_pkg::PWR_ACTIVE_MS;
        for (int f = 0; f < 4; f++)
        begin
            apb(1'b1, 8'h00, 32'(f));
            repeat (dv[f] + 2) @(posedge ref_clk_i);
            v = s;
            repeat (2 * dv[f]) @(posedge ref_clk_i);
            chk(32'(s) - v, 2);
        end
        for (int i = 0; i < 4; i++)
        begin
            mode <= lpm[i];
            v = w;
            repeat (8)
            begin
                @(posedge ref_clk_i);
                tick <= 1'b1;
                @(posedge ref_clk_i);
                tick <= 1'b0;
            end
            repeat (2) @(posedge ref_clk_i);
            chk(s, 0);
            chk(32'(w) - v, (i < 3) ? 2 : 0);
        end
        mode <= cksp_pkg::PWR_ACTIVE_HS;
        wdt <= 1'b1;
        @(posedge ref_clk_i);
        wdt <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk(osc, 1);
        chk(run, 8'hFF);
        repeat (4)
        begin
            @(posedge ref_clk_i);
            tick <= 1'b1;
            @(posedge ref_clk_i);
            tick <= 1'b0;
        end
        @(posedge ref_clk_i);
        chk(w, 1);
        pin <= 1'b0;
        rst_b_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        @(posedge ref_clk_i);
        pin <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        chk(osc, 0);
        chk(w, 0);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 0);
        stop_test;
    end
endmodule // tb_top
